// >>> hw/ulms_pkg.sv
// Package: register map, field positions and carrier types of the line and modem status block
`default_nettype none
package ulms_pkg;
   // Register offsets on the special function register port
   localparam logic [7:0] ADDR_DATA        = 8'h00_E1;
   localparam logic [7:0] ADDR_MODEM_CTRL  = 8'h00_E5;
   localparam logic [7:0] ADDR_LINE_STATUS = 8'h00_E6;
   localparam logic [7:0] ADDR_MODEM_STAT  = 8'h00_E7;

   // Modem control fields
   localparam int MC_TERM_READY  = 0;
   localparam int MC_REQ_SEND    = 1;
   localparam int MC_AUX_ONE     = 2;
   localparam int MC_AUX_TWO     = 3;
   localparam int MC_WRAP        = 4;
   localparam int MC_DIR_LO      = 6;
   localparam logic [7:0] MODEM_CTRL_RESET = 8'h00_00;

   // Line status fields
   localparam int LS_DATA_AVAIL  = 0;
   localparam int LS_OVERRUN     = 1;
   localparam int LS_PARITY      = 2;
   localparam int LS_FRAMING     = 3;
   localparam int LS_BREAK       = 4;
   localparam int LS_TX_EMPTY    = 5;
   localparam int LS_TX_ALL      = 6;
   localparam int LS_FIFO_ERR    = 7;
   localparam logic [7:0] LINE_STATUS_RESET = 8'h00_00;

   // Modem status fields: changes in 3:0, levels in 7:4
   localparam int MS_CTS_CHG     = 0;
   localparam int MS_DSR_CHG     = 1;
   localparam int MS_RING_EDGE   = 2;
   localparam int MS_DCD_CHG     = 3;
   localparam int MS_LEVEL_LO    = 4;
   localparam logic [7:0] MODEM_STAT_RESET = 8'h00_00;

   // Transceiver direction mode encodings
   localparam logic [1:0] DIR_SLEEP       = 2'h0;
   localparam logic [1:0] DIR_HALF        = 2'h1;
   localparam logic [1:0] DIR_FULL_SLAVE  = 2'h2;
   localparam logic [1:0] DIR_FULL_MASTER = 2'h3;

   // Receive FIFO depth
   localparam int RX_FIFO_DEPTH = 16;

   // Received character with its error marks
   typedef struct packed {
      logic       brk;
      logic       framing;
      logic       parity;
      logic [7:0] data;
   } ulms_rx_char_s;

   // Modem lines in asserted-high form: dcd, ring, dsr, cts
   typedef struct packed {
      logic dcd;
      logic ring;
      logic dsr;
      logic cts;
   } ulms_modem_s;
endpackage : ulms_pkg
`default_nettype wire

// >>> hw/ulms_rx_fifo.sv
// Receive FIFO holding characters with their error marks and an error census
`default_nettype none
module ulms_rx_fifo #(
   parameter int DEPTH = ulms_pkg::RX_FIFO_DEPTH
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic                   flush,
   input  wire logic                   push,
   input  wire ulms_pkg::ulms_rx_char_s push_char,
   input  wire logic                   pop,
   output ulms_pkg::ulms_rx_char_s     head,
   output logic                        empty,
   output logic                        full,
   output logic                        any_err
);
   localparam int AW = $clog2(DEPTH);

   // Power of two keeps pointer wrap free
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
      $error("ulms_rx_fifo: DEPTH must be a power of two, at least 2");
   end

   ulms_pkg::ulms_rx_char_s mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic [AW:0]   err_q;
   logic          do_push;
   logic          do_pop;
   logic          push_err;
   logic          pop_err;

   assign empty    = (cnt_q == '0);
   assign full     = (cnt_q == (AW+1)'(DEPTH));
   assign do_push  = push & ~full;
   assign do_pop   = pop & ~empty;
   assign head     = mem_q[rd_q];
   assign push_err = push_char.parity | push_char.framing | push_char.brk;
   assign pop_err  = head.parity | head.framing | head.brk;
   assign any_err  = (err_q != '0);

   // Storage, no reset needed for the data array
   always_ff @(posedge ref_clk) begin
      if (do_push) begin
         mem_q[wr_q] <= push_char;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_q + AW'(do_push);
         rd_q  <= rd_q + AW'(do_pop);
         cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // Count of entries that carry any error mark
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         err_q <= '0;
      end else if (flush) begin
         err_q <= '0;
      end else begin
         err_q <= err_q + (AW+1)'(do_push & push_err) - (AW+1)'(do_pop & pop_err);
      end
   end
endmodule : ulms_rx_fifo
`default_nettype wire

// >>> hw/ulms_top.sv
// Line and modem status block: wrap mode, transceiver enables, status registers
// Function
// - Wrap mode holds serial_tx_line high, feeds transmit shifter into receiver.
// - Wrap mode loops terminal ready, request send, aux one, aux two internally.
// - Half- and full-duplex modes raise driver_enable while transmit FIFO is not empty.
// - Half-duplex mode drives receiver enable high only while transmitting.
// - Sleep mode holds receiver enable high.
// - Full-duplex modes hold receiver enable low.
// - Data available flag follows receive FIFO holding a character.
// - Character arriving at full FIFO sets overrun and raises line interrupt.
// - Parity error at FIFO head sets parity flag, raises line interrupt.
// - Missing stop bit at FIFO head sets framing flag, raises line interrupt.
// - Break sets break flag, pushes zero character, raises line interrupt.
// - Line status read clears overrun, parity, framing, break flags; summary only once no marked character is stored.
// - Transmit FIFO empty flag set when empty, cleared by data write.
// - All-empty flag needs FIFO and shifter empty, cleared by data write.
// - Summary flag set while any FIFO character carries an error.
// - Clear-to-send, set-ready and carrier changes set their change flags.
// - Ring trailing edge flag set only on ring line low to high.
// - Status bits 7:4 report inverted inputs, or outputs in wrap mode.
// - Line interrupt has top priority, cleared by line status read.
// - Modem interrupt has lowest priority, cleared by modem status read.
`default_nettype none
module ulms_top #(
   parameter int RX_DEPTH = ulms_pkg::RX_FIFO_DEPTH
) (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   // Special function register port
   input  wire logic [7:0]          sfr_addr,
   input  wire logic                sfr_rd,
   input  wire logic                sfr_wr,
   input  wire logic [7:0]          sfr_wdata,
   input  wire logic                divisor_access,
   output logic [7:0]               sfr_rdata,
   // Receive shift register side
   input  wire logic                rx_char_valid,
   input  wire ulms_pkg::ulms_rx_char_s rx_char,
   input  wire logic                rx_fifo_flush,
   output logic                     rx_serial_in,
   // Transmit side
   input  wire logic                tx_shift_out,
   input  wire logic                tx_shift_busy,
   input  wire logic                tx_fifo_nonempty,
   output logic                     tx_data_write,
   output logic [7:0]               tx_data,
   // Pins
   input  wire logic                serial_rx_pin,
   output logic                     serial_tx_line,
   input  wire logic                clear_to_send_n,
   input  wire logic                set_ready_n,
   input  wire logic                bell_line_n,
   input  wire logic                carrier_detect_n,
   output logic                     request_send_n,
   output logic                     terminal_ready_n,
   output logic                     driver_enable,
   output logic                     rx_transceiver_enable_n,
   // Interrupt sources for the identification logic
   output logic                     line_status_irq,
   output logic                     rx_data_irq,
   output logic                     tx_empty_irq,
   output logic                     modem_status_irq
);
   ulms_pkg::ulms_rx_char_s head;
   ulms_pkg::ulms_rx_char_s push_char;
   ulms_pkg::ulms_modem_s   pins_s1_q;
   ulms_pkg::ulms_modem_s   pins_s2_q;
   ulms_pkg::ulms_modem_s   level;
   ulms_pkg::ulms_modem_s   level_prev_q;
   logic [7:0] mctrl_q;
   logic [1:0] dir_mode;
   logic       wrap;
   logic       rx_pin_s1_q;
   logic       rx_pin_s2_q;
   logic       fifo_empty;
   logic       fifo_full;
   logic       fifo_err;
   logic       fifo_push;
   logic       fifo_pop;
   logic       head_new_q;
   logic       ls_read;
   logic       ms_read;
   logic       data_read;
   logic       data_write;
   logic       overrun_q;
   logic       parity_q;
   logic       framing_q;
   logic       break_q;
   logic       fifo_err_q;
   logic       tx_empty_q;
   logic       tx_all_q;
   logic [3:0] change_q;
   logic [3:0] change_set;
   logic [7:0] line_status;
   logic [7:0] modem_status;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic       txd_q;
   logic       rxs_q;

   // Address decode shared by reads and writes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
      hit = (a == reg_addr);
   endfunction : hit

   assign ls_read    = sfr_rd & hit(sfr_addr, ulms_pkg::ADDR_LINE_STATUS);
   assign ms_read    = sfr_rd & hit(sfr_addr, ulms_pkg::ADDR_MODEM_STAT);
   assign data_read  = sfr_rd & ~divisor_access & hit(sfr_addr, ulms_pkg::ADDR_DATA);
   assign data_write = sfr_wr & ~divisor_access & hit(sfr_addr, ulms_pkg::ADDR_DATA);

   // Modem control register, write only from software
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mctrl_q <= ulms_pkg::MODEM_CTRL_RESET;
      end else if (sfr_wr && hit(sfr_addr, ulms_pkg::ADDR_MODEM_CTRL)) begin
         mctrl_q <= sfr_wdata;
      end
   end

   assign wrap     = mctrl_q[ulms_pkg::MC_WRAP];
   assign dir_mode = mctrl_q[ulms_pkg::MC_DIR_LO +: 2];

   // Transmit data write is a pulse to the transmit FIFO
   assign tx_data_write = data_write;
   assign tx_data       = sfr_wdata;

   // Two-flop synchronisers for every pin input
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pins_s1_q   <= '1;
         pins_s2_q   <= '1;
         rx_pin_s1_q <= 1'b1;
         rx_pin_s2_q <= 1'b1;
      end else begin
         pins_s1_q   <= {carrier_detect_n, bell_line_n, set_ready_n, clear_to_send_n};
         pins_s2_q   <= pins_s1_q;
         rx_pin_s1_q <= serial_rx_pin;
         rx_pin_s2_q <= rx_pin_s1_q;
      end
   end

   // Serial path: wrap parks the line idle and closes the loop
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txd_q <= 1'b1;
         rxs_q <= 1'b1;
      end else begin
         txd_q <= wrap ? 1'b1 : tx_shift_out;
         rxs_q <= wrap ? tx_shift_out : rx_pin_s2_q;
      end
   end

   assign serial_tx_line = txd_q;
   assign rx_serial_in   = rxs_q;

   // Modem outputs go inactive in wrap so the far end sees nothing
   assign request_send_n   = wrap | ~mctrl_q[ulms_pkg::MC_REQ_SEND];
   assign terminal_ready_n = wrap | ~mctrl_q[ulms_pkg::MC_TERM_READY];

   // Effective modem levels, asserted high
   always_comb begin
      if (wrap) begin
         level.cts  = mctrl_q[ulms_pkg::MC_REQ_SEND];
         level.dsr  = mctrl_q[ulms_pkg::MC_TERM_READY];
         level.ring = mctrl_q[ulms_pkg::MC_AUX_ONE];
         level.dcd  = mctrl_q[ulms_pkg::MC_AUX_TWO];
      end else begin
         level = ~pins_s2_q;
      end
   end

   // Transceiver enables from the direction mode
   always_comb begin
      driver_enable           = 1'b0;
      rx_transceiver_enable_n = 1'b0;
      unique case (dir_mode)
         ulms_pkg::DIR_SLEEP: begin
            rx_transceiver_enable_n = 1'b1;
         end
         ulms_pkg::DIR_HALF: begin
            driver_enable           = tx_fifo_nonempty;
            rx_transceiver_enable_n = tx_fifo_nonempty | tx_shift_busy;
         end
         ulms_pkg::DIR_FULL_SLAVE, ulms_pkg::DIR_FULL_MASTER: begin
            driver_enable           = tx_fifo_nonempty;
            rx_transceiver_enable_n = 1'b0;
         end
      endcase
   end

   // Break enters the FIFO as one all-zero character
   always_comb begin
      push_char = rx_char;
      if (rx_char.brk) begin
         push_char.data = '0;
      end
   end

   // Overrun drops the new character and leaves the FIFO alone
   assign fifo_push = rx_char_valid & ~fifo_full;
   assign fifo_pop  = data_read;

   ulms_rx_fifo #(
      .DEPTH (RX_DEPTH)
   ) u_rx_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .flush     (rx_fifo_flush),
      .push      (fifo_push),
      .push_char (push_char),
      .pop       (fifo_pop),
      .head      (head),
      .empty     (fifo_empty),
      .full      (fifo_full),
      .any_err   (fifo_err)
   );

   // Pulse the cycle a new character reaches the head
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         head_new_q <= 1'b0;
      end else begin
         head_new_q <= ~rx_fifo_flush & (fifo_pop | (fifo_push & fifo_empty));
      end
   end

   // Receive error flags; a new event beats the read clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         overrun_q <= 1'b0;
         parity_q  <= 1'b0;
         framing_q <= 1'b0;
         break_q   <= 1'b0;
      end else begin
         overrun_q <= (overrun_q & ~ls_read) | (rx_char_valid & fifo_full);
         parity_q  <= (parity_q & ~ls_read) | (head_new_q & ~fifo_empty & head.parity);
         framing_q <= (framing_q & ~ls_read) | (head_new_q & ~fifo_empty & head.framing);
         break_q   <= (break_q & ~ls_read) | (head_new_q & ~fifo_empty & head.brk);
      end
   end

   // Summary stays set while any marked character remains stored
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fifo_err_q <= 1'b0;
      end else begin
         fifo_err_q <= (fifo_err_q & ~ls_read) | fifo_err;
      end
   end

   // Transmit emptiness; the write clears at once, before the FIFO count moves
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_empty_q <= ulms_pkg::LINE_STATUS_RESET[ulms_pkg::LS_TX_EMPTY];
         tx_all_q   <= ulms_pkg::LINE_STATUS_RESET[ulms_pkg::LS_TX_ALL];
      end else begin
         tx_empty_q <= ~tx_fifo_nonempty & ~data_write;
         tx_all_q   <= ~tx_fifo_nonempty & ~tx_shift_busy & ~data_write;
      end
   end

   // Change detectors on the effective levels
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         level_prev_q <= '0;
      end else begin
         level_prev_q <= level;
      end
   end

   // Ring trailing edge: line goes low to high, so asserted level falls
   assign change_set[ulms_pkg::MS_CTS_CHG]   = level.cts ^ level_prev_q.cts;
   assign change_set[ulms_pkg::MS_DSR_CHG]   = level.dsr ^ level_prev_q.dsr;
   assign change_set[ulms_pkg::MS_RING_EDGE] = level_prev_q.ring & ~level.ring;
   assign change_set[ulms_pkg::MS_DCD_CHG]   = level.dcd ^ level_prev_q.dcd;

   // Change flags clear on modem status read unless a change lands then
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         change_q <= ulms_pkg::MODEM_STAT_RESET[3:0];
      end else begin
         change_q <= (change_q & ~{4{ms_read}}) | change_set;
      end
   end

   // Register images
   always_comb begin
      line_status = ulms_pkg::LINE_STATUS_RESET;
      line_status[ulms_pkg::LS_DATA_AVAIL] = ~fifo_empty;
      line_status[ulms_pkg::LS_OVERRUN]    = overrun_q;
      line_status[ulms_pkg::LS_PARITY]     = parity_q;
      line_status[ulms_pkg::LS_FRAMING]    = framing_q;
      line_status[ulms_pkg::LS_BREAK]      = break_q;
      line_status[ulms_pkg::LS_TX_EMPTY]   = tx_empty_q;
      line_status[ulms_pkg::LS_TX_ALL]     = tx_all_q;
      line_status[ulms_pkg::LS_FIFO_ERR]   = fifo_err_q;
   end

   assign modem_status = {level, change_q};

   // Read mux; unmapped offsets read zero
   always_comb begin
      rdata_d = '0;
      if (ls_read) begin
         rdata_d = line_status;
      end else if (ms_read) begin
         rdata_d = modem_status;
      end else if (data_read) begin
         rdata_d = fifo_empty ? '0 : head.data;
      end
   end

   // Read data lands one cycle after the strobe and holds until next read
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (sfr_rd) begin
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata = rdata_q;

   // Interrupt sources; priority is resolved by the identification logic
   assign line_status_irq  = overrun_q | parity_q | framing_q | break_q;
   assign rx_data_irq      = ~fifo_empty;
   assign tx_empty_irq     = tx_empty_q;
   assign modem_status_irq = |change_q;
endmodule : ulms_top
`default_nettype wire

// >>> dv/ulms_top_assertions.sv
// Checker: port-level assertions of the status block
`default_nettype none
module ulms_top_assertions (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_rd,
   input wire logic       sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       tx_shift_out,
   input wire logic       tx_shift_busy,
   input wire logic       tx_fifo_nonempty,
   input wire logic       tx_data_write,
   input wire logic       rx_serial_in,
   input wire logic       serial_tx_line,
   input wire logic       request_send_n,
   input wire logic       terminal_ready_n,
   input wire logic       driver_enable,
   input wire logic       rx_transceiver_enable_n,
   input wire logic       line_status_irq,
   input wire logic       rx_data_irq,
   input wire logic       tx_empty_irq,
   input wire logic       modem_status_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctrl_q;
   logic       up_q;
   logic       wrap;
   logic [1:0] dir;
   logic [3:0] wrap_lvl;
   // Write-only control shadow
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 8'h00;
      end else if (sfr_wr && sfr_addr == ulms_pkg::ADDR_MODEM_CTRL) begin
         ctrl_q <= sfr_wdata;
      end
   end
   // Masks first edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         up_q <= 1'b0;
      end else begin
         up_q <= 1'b1;
      end
   end
   assign wrap     = ctrl_q[ulms_pkg::MC_WRAP];
   assign dir      = ctrl_q[7:6];
   assign wrap_lvl = {ctrl_q[3], ctrl_q[2], ctrl_q[0], ctrl_q[1]};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_rd(a);
      sfr_rd && sfr_addr == a;
   endsequence
   a_wrap_tx_high: assert property (wrap && $past(wrap) |-> serial_tx_line)
      else $error("tx line not idle in wrap");
   a_tx_follow: assert property (up_q && !wrap && !$past(wrap) |-> serial_tx_line == $past(tx_shift_out))
      else $error("tx line not following shifter");
   a_wrap_rx_feed: assert property (up_q && wrap && $past(wrap) |-> rx_serial_in == $past(tx_shift_out))
      else $error("receiver not fed by shifter");
   a_modem_out_pins: assert property (request_send_n == (wrap || !ctrl_q[1]) && terminal_ready_n == (wrap || !ctrl_q[0]))
      else $error("modem output pins wrong");
   a_de_auto: assert property (driver_enable == (dir != ulms_pkg::DIR_SLEEP && tx_fifo_nonempty))
      else $error("driver enable wrong");
   a_re_modes: assert property (rx_transceiver_enable_n == (dir == ulms_pkg::DIR_SLEEP ||
      (dir == ulms_pkg::DIR_HALF && (tx_fifo_nonempty || tx_shift_busy))))
      else $error("receiver enable wrong");
   a_ready_read: assert property (s_rd(ulms_pkg::ADDR_LINE_STATUS) |=> sfr_rdata[0] == $past(rx_data_irq))
      else $error("data available bit wrong");
   a_line_irq_flags: assert property (s_rd(ulms_pkg::ADDR_LINE_STATUS) && line_status_irq |=> |sfr_rdata[4:1])
      else $error("line interrupt without flag");
   a_modem_irq_flags: assert property (s_rd(ulms_pkg::ADDR_MODEM_STAT) |=>
      (|sfr_rdata[3:0]) == $past(modem_status_irq))
      else $error("modem irq and flags differ");
   a_tx_fifo_empty_flag_write: assert property (tx_data_write |=> !tx_empty_irq)
      else $error("tx empty not cleared");
   a_tx_fifo_empty_flag_follow: assert property (up_q && !$past(tx_data_write) |-> tx_empty_irq == !$past(tx_fifo_nonempty))
      else $error("tx empty not following fifo");
   a_wrap_levels: assert property (s_rd(ulms_pkg::ADDR_MODEM_STAT) && wrap |=>
      sfr_rdata[7:4] == $past(wrap_lvl))
      else $error("wrap mode levels wrong");
endmodule : ulms_top_assertions
bind ulms_top ulms_top_assertions ulms_top_assertions_i (.ref_clk, .rst, .sfr_addr, .sfr_rd, .sfr_wr,
   .sfr_wdata, .sfr_rdata, .tx_shift_out, .tx_shift_busy, .tx_fifo_nonempty, .tx_data_write, .rx_serial_in,
   .serial_tx_line, .request_send_n, .terminal_ready_n, .driver_enable, .rx_transceiver_enable_n,
   .line_status_irq, .rx_data_irq, .tx_empty_irq, .modem_status_irq);
`default_nettype wire

// >>> dv/ulms_line_model.sv
// Far-side model: modem and receive lines of the attached equipment
`default_nettype none
module ulms_line_model (
   input  wire ulms_pkg::ulms_modem_s lines,
   input  wire logic             rx_mark,
   output logic                  clear_to_send_n,
   output logic                  set_ready_n,
   output logic                  bell_line_n,
   output logic                  carrier_detect_n,
   output logic                  serial_rx_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Active-low pins, changing off the clock edge
   assign #2 clear_to_send_n  = ~lines.cts;
   assign #2 set_ready_n      = ~lines.dsr;
   assign #2 bell_line_n      = ~lines.ring;
   assign #2 carrier_detect_n = ~lines.dcd;
   assign #2 serial_rx_pin    = rx_mark;
endmodule : ulms_line_model
`default_nettype wire

// >>> dv/ulms_top_tb.sv
// Testbench: self-checking scenarios for the status block
`default_nettype none
module ulms_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEPTH = 4;
   logic ref_clk = 1'b0, rst = 1'b1, sfr_rd = 1'b0, sfr_wr = 1'b0, divisor_access = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, tx_data;
   logic rx_char_valid = 1'b0, rx_fifo_flush = 1'b0, tx_shift_out = 1'b0, tx_shift_busy = 1'b0;
   logic tx_fifo_nonempty = 1'b0, rx_mark = 1'b1, rx_serial_in, tx_data_write, serial_rx_pin, serial_tx_line;
   logic clear_to_send_n, set_ready_n, bell_line_n, carrier_detect_n, request_send_n, terminal_ready_n;
   logic driver_enable, rx_transceiver_enable_n, line_status_irq, rx_data_irq, tx_empty_irq, modem_status_irq;
   ulms_pkg::ulms_rx_char_s rx_char = '0;
   ulms_pkg::ulms_modem_s   lines = '0;
   int err_total = 0, checks = 0, cycles = 0;
   logic t;

   ulms_top #(.RX_DEPTH(DEPTH)) ulms_top_i (.ref_clk, .rst, .sfr_addr, .sfr_rd, .sfr_wr, .sfr_wdata,
      .divisor_access, .sfr_rdata, .rx_char_valid, .rx_char, .rx_fifo_flush, .rx_serial_in, .tx_shift_out,
      .tx_shift_busy, .tx_fifo_nonempty, .tx_data_write, .tx_data, .serial_rx_pin, .serial_tx_line,
      .clear_to_send_n, .set_ready_n, .bell_line_n, .carrier_detect_n, .request_send_n, .terminal_ready_n,
      .driver_enable, .rx_transceiver_enable_n, .line_status_irq, .rx_data_irq, .tx_empty_irq, .modem_status_irq);
   ulms_line_model ulms_line_model_i (.lines, .rx_mark, .clear_to_send_n, .set_ready_n, .bell_line_n,
      .carrier_detect_n, .serial_rx_pin);

   always #5 ref_clk = ~ref_clk;
   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         summarize();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
         err_total++;
      end
   endtask : chk
   // Strobes move on falling edges
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge ref_clk);
      sfr_rd = 1'b0;
      chk(sfr_rdata, e);
   endtask : rc
   task automatic rls(input logic [7:0] e);
      rc(ulms_pkg::ADDR_LINE_STATUS, e);
   endtask : rls
   task automatic rms(input logic [7:0] e);
      rc(ulms_pkg::ADDR_MODEM_STAT, e);
   endtask : rms
   task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic taken);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      #1 taken = tx_data_write && tx_data === v;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask : wr
   task automatic push(input logic [10:0] c);
      @(negedge ref_clk);
      rx_char = c;
      rx_char_valid = 1'b1;
      @(negedge ref_clk);
      rx_char_valid = 1'b0;
   endtask : push
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : idle

   task automatic t_reset_map();
      rls(8'h60);
      rms(8'h00);
      rc(8'hE0, 8'h00);
      rc(ulms_pkg::ADDR_MODEM_CTRL, 8'h00);
   endtask : t_reset_map
   task automatic t_parity();
      push(11'h1A5);
      idle(3);
      chk(line_status_irq, 8'h01);
      rls(8'hE5);
      chk(line_status_irq, 8'h00);
      rls(8'hE1);
      rc(ulms_pkg::ADDR_DATA, 8'hA5);
      idle(3);
      rls(8'hE0);
   endtask : t_parity
   task automatic t_frame_break();
      push(11'h23C);
      push(11'h477);
      idle(3);
      rls(8'hE9);
      rc(ulms_pkg::ADDR_DATA, 8'h3C);
      idle(3);
      rls(8'hF1);
      rc(ulms_pkg::ADDR_DATA, 8'h00);
      idle(3);
      rls(8'hE0);
   endtask : t_frame_break
   task automatic t_overrun();
      for (int i = 1; i <= DEPTH + 1; i++) begin
         push({3'b000, 4'(i), 4'(i)});
      end
      idle(2);
      chk(line_status_irq, 8'h01);
      rls(8'h63);
      rls(8'h61);
      rc(ulms_pkg::ADDR_DATA, 8'h11);
      @(negedge ref_clk);
      rx_fifo_flush = 1'b1;
      @(negedge ref_clk);
      rx_fifo_flush = 1'b0;
      idle(2);
      rls(8'h60);
   endtask : t_overrun
   task automatic t_modem();
      logic [3:0] pat [5] = '{4'h1, 4'hB, 4'hF, 4'hB, 4'h0};
      logic [7:0] e1 [5] = '{8'h11, 8'hBA, 8'hF0, 8'hB4, 8'h0B};
      for (int i = 0; i < 5; i++) begin
         @(negedge ref_clk);
         lines = pat[i];
         idle(6);
         chk(modem_status_irq, |e1[i][3:0]);
         rms(e1[i]);
         rms({e1[i][7:4], 4'h0});
      end
   endtask : t_modem
   task automatic t_wrap();
      wr(ulms_pkg::ADDR_MODEM_CTRL, 8'h15, t);
      idle(7);
      rms(8'h62);
      for (int v = 0; v < 4; v++) begin
         @(negedge ref_clk);
         tx_shift_out = v[0];
         rx_mark = ~v[0];
         @(negedge ref_clk);
         chk({serial_tx_line, rx_serial_in, request_send_n, terminal_ready_n}, {1'b1, v[0], 2'b11});
      end
      rx_mark = 1'b1;
      wr(ulms_pkg::ADDR_MODEM_CTRL, 8'h03, t);
      idle(7);
      rms(8'h06);
      chk({request_send_n, terminal_ready_n, serial_tx_line}, 8'h01);
      tx_shift_out = 1'b0;
      @(negedge ref_clk);
      chk(serial_tx_line, 8'h00);
   endtask : t_wrap
   task automatic t_xcvr();
      for (int d = 0; d < 4; d++) begin
         wr(ulms_pkg::ADDR_MODEM_CTRL, {2'(d), 6'h00}, t);
         for (int k = 0; k < 4; k++) begin
            tx_fifo_nonempty = k[1];
            tx_shift_busy = k[0];
            #1 chk({driver_enable, rx_transceiver_enable_n},
               {d != 0 && k[1], d == 0 || (d == 1 && k != 0)});
            @(negedge ref_clk);
         end
      end
      tx_fifo_nonempty = 1'b0;
      tx_shift_busy = 1'b0;
      wr(ulms_pkg::ADDR_MODEM_CTRL, 8'h00, t);
   endtask : t_xcvr
   task automatic t_tx_flags();
      wr(ulms_pkg::ADDR_DATA, 8'h5A, t);
      tx_fifo_nonempty = 1'b1;
      chk(t, 8'h01);
      rls(8'h00);
      tx_fifo_nonempty = 1'b0;
      tx_shift_busy = 1'b1;
      idle(2);
      rls(8'h20);
      tx_shift_busy = 1'b0;
      idle(2);
      rls(8'h60);
      divisor_access = 1'b1;
      wr(ulms_pkg::ADDR_DATA, 8'h5A, t);
      chk(t, 8'h00);
      rls(8'h60);
      divisor_access = 1'b0;
   endtask : t_tx_flags

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      t_reset_map();
      t_parity();
      t_frame_break();
      t_overrun();
      t_modem();
      t_wrap();
      t_xcvr();
      t_tx_flags();
      summarize();
   end
endmodule : ulms_top_tb
`default_nettype wire
